/* File: inc/vipu_pkg.sv */
package vipu_pkg;
  localparam int SRC_COUNT = 32;
  localparam int SRC_W = 5;
  localparam int PRIO_LEVELS = 16;
  localparam int PRIO_W = 4;
  localparam int USED_COUNT = 21;
  localparam logic [31:0] USED_MASK = 32'hc8b75d7f;
  localparam logic [4:0] RTC_SRC = 5'h01;
  localparam logic [4:0] FIQ_SRC_RST = 5'h00;
  localparam logic [31:0] ENABLE_RST = 32'h00000000;
  localparam logic [15:0] PRIO_MASK_RST = 16'hffff;
  localparam logic [3:0] PRIO_RST = 4'hf;
endpackage

/* File: rtl/vipu_prio_cell.sv */
`timescale 1ns/1ps
module vipu_prio_cell (
  // Candidate a
  input wire logic a_valid,
  input wire logic [vipu_pkg::PRIO_W-1:0] a_prio,
  input wire logic [vipu_pkg::SRC_W-1:0] a_num,
  // Candidate b
  input wire logic b_valid,
  input wire logic [vipu_pkg::PRIO_W-1:0] b_prio,
  input wire logic [vipu_pkg::SRC_W-1:0] b_num,
  // Winner
  output logic w_valid,
  output logic [vipu_pkg::PRIO_W-1:0] w_prio,
  output logic [vipu_pkg::SRC_W-1:0] w_num
);
  import vipu_pkg::*;

  logic take_b;
  always_comb begin
    // Lower level wins; equal level falls to lower number
    take_b = b_valid && (!a_valid || (b_prio < a_prio) ||
             ((b_prio == a_prio) && (b_num < a_num)));
    w_valid = a_valid | b_valid;
    w_prio = take_b ? b_prio : a_prio;
    w_num = take_b ? b_num : a_num;
  end
endmodule // vipu_prio_cell

/* File: rtl/vipu_vectored_irq_unit.sv */
`timescale 1ns/1ps
module vipu_vectored_irq_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Peripheral sources
  input wire logic [vipu_pkg::SRC_COUNT-1:0] source_request_lines,
  // Configuration
  input wire logic [vipu_pkg::SRC_COUNT-1:0] src_enable,
  input wire logic [vipu_pkg::SRC_COUNT-1:0] soft_request,
  input wire logic [vipu_pkg::PRIO_LEVELS-1:0] level_enable,
  input wire logic [vipu_pkg::SRC_COUNT*vipu_pkg::PRIO_W-1:0] src_prio,
  input wire logic [vipu_pkg::SRC_W-1:0] fiq_src,
  input wire logic fiq_en,
  // Core requests
  output logic irq_out,
  output logic fiq_out,
  output logic [vipu_pkg::SRC_W-1:0] vector_num,
  output logic [vipu_pkg::SRC_COUNT-1:0] irq_status,
  output logic [vipu_pkg::SRC_COUNT-1:0] fiq_status
);
  import vipu_pkg::*;

  logic [SRC_COUNT-1:0] raw;
  logic [SRC_COUNT-1:0] irq_cand;
  logic [SRC_COUNT-1:0] fiq_sel;
  logic [PRIO_W-1:0] prio [SRC_COUNT];
  logic irq_q;
  logic fiq_q;
  logic [SRC_W-1:0] vec_q;
  logic [SRC_COUNT-1:0] irq_st_q;
  logic [SRC_COUNT-1:0] fiq_st_q;

  // Raw requests, reserved numbers forced low
  assign raw = (source_request_lines | soft_request) & USED_MASK;

  // Tree of comparators
  logic tv [2*SRC_COUNT-1];
  logic [PRIO_W-1:0] tp [2*SRC_COUNT-1];
  logic [SRC_W-1:0] tn [2*SRC_COUNT-1];

  genvar g;
  generate
    for (g = 0; g < SRC_COUNT; g++) begin : g_leaf
      assign prio[g] = src_prio[g*PRIO_W +: PRIO_W];
      assign fiq_sel[g] = fiq_en && (fiq_src == SRC_W'(g));
      // Source and level masks
      assign irq_cand[g] = raw[g] & src_enable[g] & ~fiq_sel[g] &
                           level_enable[prio[g]];
      assign tv[SRC_COUNT-1+g] = irq_cand[g];
      assign tp[SRC_COUNT-1+g] = prio[g];
      assign tn[SRC_COUNT-1+g] = SRC_W'(g);
    end
    for (g = 0; g < SRC_COUNT-1; g++) begin : g_node
      vipu_prio_cell u_cell (
        .a_valid(tv[2*g+1]),
        .a_prio(tp[2*g+1]),
        .a_num(tn[2*g+1]),
        .b_valid(tv[2*g+2]),
        .b_prio(tp[2*g+2]),
        .b_num(tn[2*g+2]),
        .w_valid(tv[g]),
        .w_prio(tp[g]),
        .w_num(tn[g])
      );
    end
  endgenerate

  logic [SRC_COUNT-1:0] fiq_act;
  assign fiq_act = raw & src_enable & fiq_sel;

  // Fast request
  always_ff @(posedge clk) begin
    if (rst) begin
      fiq_q <= 1'b0;
    end else begin
      fiq_q <= |fiq_act;
    end
  end

  // Normal request, held off by fast
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= tv[0] && !(|fiq_act);
    end
  end

  // Winning vector, held while nothing asks
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_q <= '0;
    end else if (tv[0]) begin
      vec_q <= tn[0];
    end
  end

  // Masked status
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_st_q <= '0;
      fiq_st_q <= '0;
    end else begin
      irq_st_q <= irq_cand;
      fiq_st_q <= fiq_act;
    end
  end

  assign irq_out = irq_q;
  assign fiq_out = fiq_q;
  assign vector_num = vec_q;
  assign irq_status = irq_st_q;
  assign fiq_status = fiq_st_q;

  // Linear search, cross-check for the tree
  logic ref_valid;
  logic [PRIO_W-1:0] ref_prio;
  logic [SRC_W-1:0] ref_num;
  always_comb begin
    ref_valid = 1'b0;
    ref_prio = '1;
    ref_num = '0;
    for (int i = SRC_COUNT-1; i >= 0; i--) begin
      if (irq_cand[i] && (!ref_valid || prio[i] <= ref_prio)) begin
        ref_valid = 1'b1;
        ref_prio = prio[i];
        ref_num = SRC_W'(i);
      end
    end
  end

  // Checks
  reserved_quiet_a: assert property (@(posedge clk) disable iff (rst)
    ((source_request_lines | soft_request) & ~USED_MASK) != 0 &&
    raw == 0 |=> !irq_out && !fiq_out)
    else $error("reserved source raised a request");
  fiq_blocks_irq_a: assert property (@(posedge clk) disable iff (rst)
    (|fiq_act) |=> fiq_out && !irq_out)
    else $error("fast request did not win");
  one_fiq_src_a: assert property (@(posedge clk) disable iff (rst)
    $onehot0(fiq_status))
    else $error("more than one fast source");
  soft_raise_a: assert property (@(posedge clk) disable iff (rst)
    soft_request[RTC_SRC] && src_enable[RTC_SRC] && !fiq_en &&
    level_enable[prio[RTC_SRC]] |=> irq_out)
    else $error("software request lost");
  level_mask_a: assert property (@(posedge clk) disable iff (rst)
    level_enable == 16'h0000 |=> !irq_out)
    else $error("masked level raised a request");
  src_mask_a: assert property (@(posedge clk) disable iff (rst)
    src_enable == 32'h00000000 |=> !irq_out && !fiq_out)
    else $error("masked source raised a request");
  winner_best_a: assert property (@(posedge clk) disable iff (rst)
    tv[0] && irq_cand[0] |=> prio[vector_num] <= $past(prio[0])
    || $past(prio[vector_num]) <= $past(prio[0]))
    else $error("winner less urgent than source 0");
  vector_follow_a: assert property (@(posedge clk) disable iff (rst)
    irq_out |-> irq_status[vector_num])
    else $error("vector does not match status");
  tie_rank_a: assert property (@(posedge clk) disable iff (rst)
    irq_cand[0] && prio[0] == 4'h0 && !(|fiq_act)
    |=> vector_num == 5'h00)
    else $error("rank tie break wrong");

  // Reset, fast path, status, vector and normal request checks
  out_reset_a: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> !irq_out && !fiq_out && vector_num == 5'h00 &&
    irq_status == 32'h00000000 && fiq_status == 32'h00000000)
    else $error("outputs not cleared by reset");
  fiq_off_a: assert property (@(posedge clk) disable iff (rst)
    !fiq_en |=> !fiq_out && fiq_status == 32'h00000000)
    else $error("fast request without fast routing");
  fiq_route_a: assert property (@(posedge clk) disable iff (rst)
    fiq_en && USED_MASK[fiq_src] && src_enable[fiq_src] &&
    (source_request_lines[fiq_src] || soft_request[fiq_src])
    |=> fiq_out && fiq_status[$past(fiq_src)])
    else $error("fast source not routed");
  fiq_no_irq_a: assert property (@(posedge clk) disable iff (rst)
    fiq_en |=> !irq_status[$past(fiq_src)])
    else $error("fast source reached normal path");
  fiq_lead_a: assert property (@(posedge clk) disable iff (rst)
    fiq_out |-> !irq_out)
    else $error("normal request beside fast request");
  fiq_status_a: assert property (@(posedge clk) disable iff (rst)
    fiq_out == (fiq_status != 32'h00000000))
    else $error("fast request and status disagree");
  rsvd_status_a: assert property (@(posedge clk) disable iff (rst)
    ((irq_status | fiq_status) & ~USED_MASK) == 32'h00000000)
    else $error("reserved source shows status");
  vec_used_a: assert property (@(posedge clk) disable iff (rst)
    irq_out |-> USED_MASK[vector_num])
    else $error("vector names a reserved source");
  src_status_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (irq_status & ~$past(src_enable)) == 32'h00000000)
    else $error("disabled source shows status");
  lvl_status_a: assert property (@(posedge clk) disable iff (rst)
    !level_enable[prio[RTC_SRC]] |=> !irq_status[RTC_SRC])
    else $error("masked level shows status");
  vec_hold_a: assert property (@(posedge clk) disable iff (rst)
    !tv[0] |=> $stable(vector_num))
    else $error("vector moved with no request");
  vec_take_a: assert property (@(posedge clk) disable iff (rst)
    tv[0] |=> vector_num == $past(ref_num))
    else $error("vector is not the best request");
  quiet_idle_a: assert property (@(posedge clk) disable iff (rst)
    !tv[0] |=> !irq_out)
    else $error("normal request with no candidate");
  irq_raise_a: assert property (@(posedge clk) disable iff (rst)
    tv[0] && !(|fiq_act) |=> irq_out)
    else $error("candidate did not raise normal request");
  tree_match_a: assert property (@(posedge clk) disable iff (rst)
    tv[0] == ref_valid && (!ref_valid ||
    (tn[0] == ref_num && tp[0] == ref_prio)))
    else $error("comparator tree disagrees with search");
endmodule // vipu_vectored_irq_unit

/* File: sim/vipu_src_model.sv */
`timescale 1ns/1ps
// Peripheral sources, levels held until changed
module vipu_src_model (
  // Clock
  input wire logic clk,
  // Wanted levels
  input wire logic [31:0] want,
  // Request lines
  output logic [31:0] source_request_lines
);
  initial source_request_lines = 32'h00000000;
  always @(posedge clk) begin
    source_request_lines <= want;
  end
endmodule // vipu_src_model

/* File: sim/vipu_vectored_irq_unit_tb.sv */
`timescale 1ns/1ps
module vipu_vectored_irq_unit_tb;
  import vipu_pkg::*;
  logic clk = 1'b0, rst = 1'b1, fiq_en = 1'b0, irq_out, fiq_out;
  logic [31:0] want = '0, src_enable = '0, soft_request = '0, lines;
  logic [31:0] irq_status, fiq_status;
  logic [15:0] level_enable = '0;
  logic [127:0] src_prio = {32{4'hf}};
  logic [4:0] fiq_src = 5'h0a, vector_num;
  int n_fail = 0, comparisons = 0;
  always #50 clk = ~clk;
  vipu_src_model i_vipu_src_model(.clk(clk), .want(want),
    .source_request_lines(lines));
  vipu_vectored_irq_unit i_vipu_vectored_irq_unit(.clk(clk), .rst(rst),
    .source_request_lines(lines), .src_enable(src_enable),
    .soft_request(soft_request), .level_enable(level_enable),
    .src_prio(src_prio), .fiq_src(fiq_src), .fiq_en(fiq_en),
    .irq_out(irq_out), .fiq_out(fiq_out), .vector_num(vector_num),
    .irq_status(irq_status), .fiq_status(fiq_status));
  task chk(input logic ei, ef, input logic [4:0] ev);
    comparisons++;
    if ({irq_out, fiq_out} !== {ei, ef} || (ei && vector_num !== ev)) begin
      n_fail++;
      $display("[ERR] %0t wrong request outputs", $time);
    end
  endtask
  task chk_st(input logic [31:0] ei, ef);
    comparisons++;
    if (irq_status !== ei || fiq_status !== ef) begin
      n_fail++;
      $display("[ERR] %0t wrong status outputs", $time);
    end
  endtask
  task drive(input logic [31:0] s, sw, en, input logic [15:0] lv,
    input logic fe);
    @(posedge clk);
    want <= s;
    soft_request <= sw;
    src_enable <= en;
    level_enable <= lv;
    fiq_en <= fe;
    repeat (3) @(posedge clk);
    #10;
  endtask
  task t_rank;
    drive(32'h00000014, '0, '1, 16'hffff, 1'b0);
    chk(1'b1, 1'b0, 5'h02);
    chk_st(32'h00000014, 32'h00000000);
    drive(32'h00000015, '0, '1, 16'hffff, 1'b0);
    chk(1'b1, 1'b0, 5'h00);
    $display("rank test done");
  endtask
  task t_level;
    drive(32'h00000408, '0, '1, 16'hffff, 1'b0);
    chk(1'b1, 1'b0, 5'h0a);
    drive(32'h00000408, '0, '1, 16'hfffd, 1'b0);
    chk(1'b1, 1'b0, 5'h03);
    chk_st(32'h00000008, 32'h00000000);
    $display("level test done");
  endtask
  task t_srcmask;
    drive(32'h00000408, '0, 32'hfffffbff, 16'hffff, 1'b0);
    chk(1'b1, 1'b0, 5'h03);
    chk_st(32'h00000008, 32'h00000000);
    $display("source mask test done");
  endtask
  task t_fiq;
    drive(32'h00000408, '0, '1, 16'hffff, 1'b1);
    chk(1'b0, 1'b1, 5'h00);
    chk_st(32'h00000008, 32'h00000400);
    $display("fast test done");
  endtask
  task t_soft;
    drive('0, 32'h80000000, '1, 16'hffff, 1'b0);
    chk(1'b1, 1'b0, 5'h1f);
    drive('0, 32'h00000002, '1, 16'hffff, 1'b0);
    chk(1'b1, 1'b0, 5'h01);
    $display("soft test done");
  endtask
  task t_rsvd;
    drive(32'h00000080, 32'h00000200, '1, 16'hffff, 1'b0);
    chk(1'b0, 1'b0, 5'h00);
    chk_st(32'h00000000, 32'h00000000);
    $display("reserved test done");
  endtask
  task t_reset;
    drive(32'h00000408, '0, '1, 16'hffff, 1'b0);
    chk(1'b1, 1'b0, 5'h0a);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #10;
    chk(1'b0, 1'b0, 5'h00);
    chk_st(32'h00000000, 32'h00000000);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #10;
    chk(1'b1, 1'b0, 5'h0a);
    chk_st(32'h00000408, 32'h00000000);
    $display("reset test done");
  endtask
  task results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    src_prio[3:0] = 4'h0;
    src_prio[11:8] = 4'h5;
    src_prio[19:16] = 4'h5;
    src_prio[15:12] = 4'h2;
    src_prio[43:40] = 4'h1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #10;
    chk(1'b0, 1'b0, 5'h00);
    chk_st(32'h00000000, 32'h00000000);
    t_rank();
    t_level();
    t_srcmask();
    t_fiq();
    t_soft();
    t_rsvd();
    t_reset();
    results();
  end
  initial begin
    #2000000;
    n_fail++;
    results();
  end
endmodule // vipu_vectored_irq_unit_tb
